// ===== verilog/cis_line_scan_readout.sv
// line-scan readout sequencer of the cascaded sensor chips
`timescale 1ns/10ps
`default_nettype none
module cis_line_scan_readout #(
    parameter int VIDEO_W = 8
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic line_start_pulse_i,
    input wire logic pixel_clock_pulse_i,
    input wire logic [VIDEO_W-1:0] pixel_charge_i,
    output logic [cis_pkg::ADDR_W-1:0] pixel_sel_o,
    output logic [VIDEO_W-1:0] analog_video_output_o,
    output logic [cis_pkg::ADDR_W-1:0] video_addr_o,
    output logic video_valid_o,
    output logic pixel_reset_o,
    output logic [cis_pkg::ADDR_W-1:0] pixel_reset_addr_o,
    output logic line_active_o
);
    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers and falling-edge detect
    logic sp_s1_q;
    logic sp_s2_q;
    logic cp_s1_q;
    logic cp_s2_q;
    logic cp_s3_q;
    logic shift;
    logic first_load;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sp_s1_q <= 1'b0;
            sp_s2_q <= 1'b0;
            cp_s1_q <= 1'b0;
            cp_s2_q <= 1'b0;
            cp_s3_q <= 1'b0;
        end else begin
            sp_s1_q <= line_start_pulse_i;
            sp_s2_q <= sp_s1_q;
            cp_s1_q <= pixel_clock_pulse_i;
            cp_s2_q <= cp_s1_q;
            cp_s3_q <= cp_s2_q;
        end
    end

    assign shift = cp_s3_q && !cp_s2_q;
    assign first_load = shift && sp_s2_q;

    //////////////////////////////////////////////////////////////////////////
    // chip cascade
    logic [cis_pkg::CHIPS:0] start_w;
    logic [cis_pkg::CHIPS:0] any_w;
    logic [cis_pkg::ADDR_W-1:0] addr_w [0:cis_pkg::CHIPS];

    assign start_w[0] = first_load;
    assign any_w[0] = 1'b0;
    assign addr_w[0] = cis_pkg::ADDR_RST;

    genvar k;
    generate
        for (k = 0; k < cis_pkg::CHIPS; k++) begin : gen_chip
            localparam logic [cis_pkg::ADDR_W-1:0] BASE = 12'(k * cis_pkg::PIX_PER_CHIP);
            cis_chip_if u_link ();
            assign u_link.shift = shift;
            assign u_link.start = start_w[k];
            assign start_w[k+1] = u_link.eol;
            assign any_w[k+1] = any_w[k] | u_link.active;
            assign addr_w[k+1] = addr_w[k] |
                (u_link.active ? (BASE | {5'h00, u_link.idx}) : cis_pkg::ADDR_RST);
            cis_chip u_chip (
                .clock_i(clock_i),
                .arst_n_i(arst_n_i),
                .link(u_link)
            );
        end
    endgenerate

    assign pixel_sel_o = addr_w[cis_pkg::CHIPS];
    assign line_active_o = any_w[cis_pkg::CHIPS];

    //////////////////////////////////////////////////////////////////////////
    // video readout and pixel reset
    logic shift_q;
    logic shift_d;
    logic [VIDEO_W-1:0] video_q;
    logic [VIDEO_W-1:0] video_d;
    logic [cis_pkg::ADDR_W-1:0] vaddr_q;
    logic [cis_pkg::ADDR_W-1:0] vaddr_d;
    logic valid_q;
    logic valid_d;
    logic rst_q;
    logic rst_d;
    logic [cis_pkg::ADDR_W-1:0] raddr_q;
    logic [cis_pkg::ADDR_W-1:0] raddr_d;

    always_comb begin
        shift_d = shift;
        video_d = video_q;
        vaddr_d = vaddr_q;
        valid_d = 1'b0;
        rst_d = valid_q;
        raddr_d = valid_q ? vaddr_q : raddr_q;
        if (shift_q && line_active_o) begin
            video_d = pixel_charge_i;
            vaddr_d = pixel_sel_o;
            valid_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_q <= 1'b0;
            video_q <= '0;
            vaddr_q <= cis_pkg::ADDR_RST;
            valid_q <= 1'b0;
            rst_q <= 1'b0;
            raddr_q <= cis_pkg::ADDR_RST;
        end else begin
            shift_q <= shift_d;
            video_q <= video_d;
            vaddr_q <= vaddr_d;
            valid_q <= valid_d;
            rst_q <= rst_d;
            raddr_q <= raddr_d;
        end
    end

    assign analog_video_output_o = video_q;
    assign video_addr_o = vaddr_q;
    assign video_valid_o = valid_q;
    assign pixel_reset_o = rst_q;
    assign pixel_reset_addr_o = raddr_q;
endmodule : cis_line_scan_readout
`default_nettype wire

// ===== verilog/cis_pkg.sv
// constants for the line-scan readout sequencer
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - each chip presents its 128 pixels in turn, so one line yields 3456 pixels.
// - all 27 chips share one shift strobe, each end-of-line starts the next, one video line.
// - a start pulse activates the first chip, which then steps one pixel per pixel-clock cycle.
// - a new line begins only on another start pulse, never on its own.
// - while a line is active, exactly one pixel leaves per cycle of the input pixel clock; none leave between lines.
// - after a pixel has been read out onto the video line it is reset for the next charge.
//////////////////////////////////////////////////////////////////////////////
package cis_pkg;
    localparam int CHIPS = 27;
    localparam int PIX_PER_CHIP = 128;
    localparam int LINE_PIXELS = CHIPS * PIX_PER_CHIP;
    localparam int IDX_W = 7;
    localparam int ADDR_W = 12;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam logic [IDX_W-1:0] IDX_LAST = 7'h7F;
    localparam logic [IDX_W-1:0] IDX_RST = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;

    typedef enum logic [1:0] {
        CIS_IDLE = 2'b01,
        CIS_RUN  = 2'b10
    } cis_chip_state_t;
endpackage : cis_pkg

// ===== verilog/cis_chip_if.sv
// link between the sequencer and one cascaded sensor chip
`timescale 1ns/10ps
`default_nettype none
interface cis_chip_if;
    logic shift;
    logic start;
    logic eol;
    logic active;
    logic [cis_pkg::IDX_W-1:0] idx;

    modport chip (
        input shift,
        input start,
        output eol,
        output active,
        output idx
    );
    modport ctrl (
        output shift,
        output start,
        input eol,
        input active,
        input idx
    );
endinterface : cis_chip_if
`default_nettype wire

// ===== verilog/cis_chip.sv
// one sensor chip shift register with chip select and end-of-line
`timescale 1ns/10ps
`default_nettype none
module cis_chip (
    input wire logic clock_i,
    input wire logic arst_n_i,
    cis_chip_if.chip link
);
    cis_pkg::cis_chip_state_t state_q;
    cis_pkg::cis_chip_state_t state_d;
    logic [cis_pkg::IDX_W-1:0] idx_q;
    logic [cis_pkg::IDX_W-1:0] idx_d;

    //////////////////////////////////////////////////////////////////////////
    // 128 pixel steps
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        if (link.shift) begin
            case (state_q)
                cis_pkg::CIS_IDLE: begin
                    if (link.start) begin
                        state_d = cis_pkg::CIS_RUN;
                        idx_d = cis_pkg::IDX_RST;
                    end
                end
                cis_pkg::CIS_RUN: begin
                    if (idx_q == cis_pkg::IDX_LAST) begin
                        state_d = link.start ? cis_pkg::CIS_RUN : cis_pkg::CIS_IDLE;
                        idx_d = cis_pkg::IDX_RST;
                    end else if (link.start) begin
                        idx_d = cis_pkg::IDX_RST;
                    end else begin
                        idx_d = idx_q + 7'h01;
                    end
                end
                default: begin
                    state_d = cis_pkg::CIS_IDLE;
                    idx_d = cis_pkg::IDX_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= cis_pkg::CIS_IDLE;
            idx_q <= cis_pkg::IDX_RST;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
        end
    end

    assign link.eol = link.shift && (state_q == cis_pkg::CIS_RUN) && (idx_q == cis_pkg::IDX_LAST);
    assign link.active = (state_q == cis_pkg::CIS_RUN);
    assign link.idx = idx_q;
endmodule : cis_chip
`default_nettype wire

// ===== tb/cis_ctrl_model.sv
// scanner controller model: free pixel clock and start pulse
`timescale 1ns/10ps
`default_nettype none
module cis_ctrl_model (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic go_i,
    input wire logic wide_i,
    output logic sp_o,
    output logic cp_o
);
    logic [2:0] ph_q;
    logic pend_q;
    logic [1:0] left_q;
    assign cp_o = (ph_q < 3'h3);
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ph_q <= 3'h0;
            pend_q <= 1'b0;
            left_q <= 2'h0;
            sp_o <= 1'b0;
        end else begin
            ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
            if (go_i) pend_q <= 1'b1;
            if (ph_q == 3'h5 && pend_q) begin
                sp_o <= 1'b1;
                left_q <= wide_i ? 2'h2 : 2'h1;
                pend_q <= 1'b0;
            end else if (ph_q == 3'h5 && left_q != 2'h0) begin
                left_q <= left_q - 2'h1;
                sp_o <= (left_q > 2'h1);
            end
        end
    end
endmodule : cis_ctrl_model
`default_nettype wire

// ===== tb/cis_line_scan_readout_checker.sv
// port assertions of the readout sequencer
`timescale 1ns/10ps
`default_nettype none
module cis_line_scan_readout_checker #(
    parameter int VIDEO_W = 8
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic line_start_pulse_i,
    input wire logic [VIDEO_W-1:0] pixel_charge_i,
    input wire logic [cis_pkg::ADDR_W-1:0] pixel_sel_o,
    input wire logic [VIDEO_W-1:0] analog_video_output_o,
    input wire logic [cis_pkg::ADDR_W-1:0] video_addr_o,
    input wire logic video_valid_o,
    input wire logic pixel_reset_o,
    input wire logic [cis_pkg::ADDR_W-1:0] pixel_reset_addr_o,
    input wire logic line_active_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    logic [cis_pkg::ADDR_W-1:0] last_d;
    logic [cis_pkg::ADDR_W-1:0] last_q;
    always_comb last_d = video_valid_o ? video_addr_o : last_q;
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) last_q <= cis_pkg::ADDR_RST;
        else last_q <= last_d;
    end
    AST_ONE_PULSE: assert property (video_valid_o |=> !video_valid_o) else $error("valid too long");
    AST_RST_NEXT: assert property (video_valid_o |=> pixel_reset_o) else $error("no pixel reset");
    AST_RST_ADDR: assert property (video_valid_o |=> pixel_reset_addr_o == $past(video_addr_o))
        else $error("reset addr");
    AST_RST_CAUSE: assert property (pixel_reset_o |-> $past(video_valid_o)) else $error("stray reset");
    AST_RANGE: assert property (video_valid_o |-> video_addr_o < 12'hD80) else $error("addr range");
    AST_STEP: assert property (video_valid_o && video_addr_o != 12'h000 |-> video_addr_o == last_q + 12'h001)
        else $error("addr step");
    AST_SEL: assert property (video_valid_o |-> video_addr_o == $past(pixel_sel_o)) else $error("sel");
    AST_DATA: assert property (video_valid_o |-> analog_video_output_o == $past(pixel_charge_i))
        else $error("video data");
    AST_ACTIVE: assert property (video_valid_o |-> $past(line_active_o)) else $error("idle sample");
    AST_START: assert property ($rose(line_active_o) |-> $past(line_start_pulse_i, 3))
        else $error("self start");
    COV_LAST: cover property (video_valid_o && video_addr_o == 12'hD7F);
    COV_HAND: cover property (video_valid_o && video_addr_o == 12'h080);
    COV_GO: cover property ($rose(line_active_o));
endmodule : cis_line_scan_readout_checker
bind cis_line_scan_readout cis_line_scan_readout_checker #(.VIDEO_W(VIDEO_W)) u_chk (.*);
`default_nettype wire

// ===== tb/test_cis_line_scan_readout.sv
// self-checking bench of the readout sequencer
`timescale 1ns/10ps
`default_nettype none
module test_cis_line_scan_readout;
    typedef struct {int chip; int pix; logic [11:0] addr;} cis_row_t;
    logic clock_i, arst_n_i, go, wide, sp, cp, valid, rst_p, act;
    logic [7:0] charge, video;
    logic [11:0] sel, vaddr, raddr;
    logic [11:0] seen [0:8191];
    int n_fail, n_compared, n_seen, base, i;
    logic rst_due = 1'b0;
    logic [11:0] rst_exp;
    time t_go;
    cis_row_t rows [5] = '{'{0, 0, 12'h000}, '{0, 127, 12'h07F}, '{1, 0, 12'h080},
        '{14, 0, 12'h700}, '{26, 127, 12'hD7F}};
    assign charge = sel[7:0] ^ 8'hA5;
    always #10 clock_i = ~clock_i;
    cis_ctrl_model u_ctrl (.clock_i(clock_i), .arst_n_i(arst_n_i), .go_i(go), .wide_i(wide),
        .sp_o(sp), .cp_o(cp));
    cis_line_scan_readout dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .line_start_pulse_i(sp),
        .pixel_clock_pulse_i(cp), .pixel_charge_i(charge), .pixel_sel_o(sel),
        .analog_video_output_o(video), .video_addr_o(vaddr), .video_valid_o(valid),
        .pixel_reset_o(rst_p), .pixel_reset_addr_o(raddr), .line_active_o(act));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        if (s !== e) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
            n_fail++;
        end
        n_compared++;
    endtask : chk
    task automatic conclude;
        $display("fails=%0d compared=%0d", n_fail, n_compared);
        if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    task automatic wait_n(input int n);
        for (int k = 0; k < 30000 && n_seen < n; k++) @(posedge clock_i);
    endtask : wait_n
    always @(posedge clock_i) begin
        if (rst_due) chk({3'h0, rst_p, raddr}, {4'h1, rst_exp});
        rst_due = (valid === 1'b1);
        rst_exp = vaddr;
        if (valid === 1'b1) begin
            seen[n_seen] = vaddr;
            n_seen++;
            chk(video, vaddr[7:0] ^ 8'hA5);
        end
    end
    initial begin
        {clock_i, arst_n_i, go, wide, n_fail, n_compared, n_seen} = '0;
        repeat (10) @(posedge clock_i);
        chk({valid, rst_p, act, sel}, 16'h0000);
        arst_n_i <= 1'b1;
        repeat (60) @(posedge clock_i);
        chk(16'(n_seen), 16'h0000);
        go <= 1'b1;
        t_go = $time;
        @(posedge clock_i) go <= 1'b0;
        wait_n(3456);
        repeat (300) @(posedge clock_i);
        chk(16'(n_seen), 16'h0D80);
        for (i = 0; i < 5; i++) chk(seen[rows[i].chip * 128 + rows[i].pix], rows[i].addr);
        chk(act, 1'b0);
        while ($time - t_go < 64'd631000) @(posedge clock_i);
        base = n_seen;
        wide <= 1'b1;
        go <= 1'b1;
        @(posedge clock_i) go <= 1'b0;
        wait_n(base + 3);
        chk(16'(seen[base]), 16'h0000);
        chk(16'(seen[base + 1]), 16'h0000);
        chk(16'(seen[base + 2]), 16'h0001);
        conclude();
    end
    initial begin
        repeat (40000) @(posedge clock_i);
        n_fail++;
        conclude();
    end
endmodule : test_cis_line_scan_readout
`default_nettype wire
